// file: mcb_csr_bank.sv
// Machine CSR bank: storage, read mux, access checks, trap enable save/restore.
// Assumes the core issues one CSR access per request pulse with the final
// write value already computed, and pulses trap entry and return.
`timescale 1ns/1ps
`include "mcb_consts.svh"
module mcb_csr_bank
  import mcb_pkg::*;
#(
  parameter bit        EXT_U   = 1'b1,
  parameter bit        EXT_M   = 1'b1,
  parameter bit        EXT_C   = 1'b1,
  parameter bit        EXT_A   = 1'b0,
  parameter bit        EXT_E   = 1'b0,
  parameter bit        EXT_FP  = 1'b1,
  parameter mcb_word_t MAKER   = 32'h0000_0000, // Arbitrary value
  parameter mcb_word_t ARCH    = 32'h0000_0000, // Arbitrary value
  parameter mcb_word_t IMPL    = 32'h0000_0001, // Arbitrary value
  parameter mcb_word_t THREAD  = 32'h0000_0000,
  parameter mcb_word_t XISA    = 32'h0000_0001
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // CSR access port
  input  wire logic        csr_req,
  input  wire logic        csr_wr,
  input  wire mcb_addr_t   csr_addr,
  input  wire mcb_word_t   csr_wdata,
  input  wire mcb_priv_e   priv,
  output logic             csr_ack,
  output logic             csr_illegal,
  output mcb_word_t        csr_rdata,
  // Trap sequencing
  input  wire logic        trap_entry,
  input  wire logic        trap_return,
  input  wire mcb_word_t   trap_pc,
  input  wire mcb_word_t   trap_cause,
  input  wire mcb_word_t   trap_value,
  // Event sources
  input  wire logic        irq_ext,
  input  wire logic        irq_timer,
  input  wire logic [15:0] fast_irq_channel,
  input  wire logic [4:0]  fp_flags_set,
  input  wire logic        retire,
  input  wire logic [31:0] perf_events,
  input  wire logic [63:0] machine_timer_unit,
  // Core controls
  output logic             irq_take,
  output logic [2:0]       fp_round_mode,
  output logic             timeout_wait_disallow,
  output logic [1:0]       previous_privilege,
  output mcb_word_t        trap_vector,
  output mcb_word_t        return_pc
);

  logic [4:0]  fp_flags_reg;
  logic [2:0]  fp_rnd_reg;
  logic        wait_blk_reg, prev_gie_reg, gie_reg;
  logic [1:0]  prev_priv_reg;
  logic [15:0] fast_en_reg, fast_pend_reg;
  logic        ext_en_reg, tim_en_reg;
  logic [31:2] tvec_reg;
  logic [2:0]  cnten_reg;
  logic [31:0] inhibit_reg, scratch_reg, epc_reg, tval_reg;
  logic        cause_irq_reg;
  logic [4:0]  cause_id_reg;
  logic [31:0] pcfg_reg [4];
  logic [31:0] paddr_reg [16];
  logic [31:0] hpm_ev_reg [32];
  logic [63:0] hpm_cnt_reg [32];
  logic [63:0] cyc_reg, ret_reg;
  logic        ack_reg, ill_reg, irq_reg;
  mcb_word_t   rdata_reg, rd_word;
  logic        known, ro, ill, wr_ok;
  logic [4:0]  hidx;

  function automatic logic in_rng(input mcb_addr_t a, input mcb_addr_t b, input mcb_addr_t n);
    in_rng = (a >= b) && (a < b + n);
  endfunction

  function automatic logic hit(input logic ok, input mcb_addr_t a, input mcb_addr_t b);
    hit = ok && (a == b);
  endfunction

  assign hidx = csr_addr[4:0];

  function automatic mcb_word_t isa_word();
    mcb_word_t w;
    w = 32'h0;
    w[`MCB_B_WLEN+1:`MCB_B_WLEN] = `MCB_WLEN_32;
    w[`MCB_B_X] = 1'b1;
    w[`MCB_B_U] = EXT_U;
    w[`MCB_B_M] = EXT_M;
    w[`MCB_B_C] = EXT_C;
    w[`MCB_B_A] = EXT_A;
    w[`MCB_B_E] = EXT_E;
    w[`MCB_B_I] = ~EXT_E;
    return w;
  endfunction

  // Read mux; unlisted bits stay zero
  always_comb begin
    rd_word = 32'h0;
    known   = 1'b1;
    ro      = 1'b0;
    if (in_rng(csr_addr, `MCB_A_PCFG, 12'h4)) begin
      rd_word = pcfg_reg[csr_addr[1:0]];
    end else if (in_rng(csr_addr, `MCB_A_PADDR, 12'h10)) begin
      rd_word = paddr_reg[csr_addr[3:0]];
    end else if (in_rng(csr_addr, `MCB_A_HPMEV, 12'h1D)) begin
      rd_word = hpm_ev_reg[hidx];
    end else if (in_rng(csr_addr, `MCB_A_HPMLO, 12'h1D)) begin
      rd_word = hpm_cnt_reg[hidx][31:0];
    end else if (in_rng(csr_addr, `MCB_A_HPMHI, 12'h1D)) begin
      rd_word = hpm_cnt_reg[hidx][63:32];
    end else begin
      case (csr_addr)
        `MCB_A_FPFLAG: begin
          rd_word = {27'h0, fp_flags_reg};
          known   = EXT_FP;
        end
        `MCB_A_FPRND: begin
          rd_word = {29'h0, fp_rnd_reg};
          known   = EXT_FP;
        end
        `MCB_A_FPCTL: begin
          rd_word = {24'h0, fp_rnd_reg, fp_flags_reg};
          known   = EXT_FP;
        end
        `MCB_A_STATUS: begin
          rd_word[`MCB_B_WFIBLK] = wait_blk_reg;
          rd_word[`MCB_B_PPRIV+1:`MCB_B_PPRIV] = prev_priv_reg;
          rd_word[`MCB_B_PGIE] = prev_gie_reg;
          rd_word[`MCB_B_GIE] = gie_reg;
        end
        `MCB_A_ISA:     rd_word = isa_word();
        `MCB_A_IEN: begin
          rd_word[31:`MCB_B_FAST] = fast_en_reg;
          rd_word[`MCB_B_EXT] = ext_en_reg;
          rd_word[`MCB_B_TIM] = tim_en_reg;
        end
        `MCB_A_TVEC:    rd_word = {tvec_reg, 2'b00};
        `MCB_A_CNTEN: begin
          rd_word = {29'h0, cnten_reg};
          known   = EXT_U;
        end
        `MCB_A_ENVLO, `MCB_A_ENVHI: begin
          known = EXT_U;
          ro    = 1'b1;
        end
        `MCB_A_MSTATH:  ro = 1'b1;
        `MCB_A_INHIBIT: rd_word = inhibit_reg;
        `MCB_A_SCRATCH: rd_word = scratch_reg;
        `MCB_A_EPC:     rd_word = epc_reg;
        `MCB_A_CAUSE:   rd_word = {cause_irq_reg, 26'h0, cause_id_reg};
        `MCB_A_TVAL:    rd_word = tval_reg;
        `MCB_A_PEND: begin
          rd_word[31:`MCB_B_FAST] = fast_pend_reg;
          rd_word[`MCB_B_EXT] = irq_ext;
          rd_word[`MCB_B_TIM] = irq_timer;
        end
        `MCB_A_MCYC, `MCB_A_CYC:   rd_word = cyc_reg[31:0];
        `MCB_A_MCYCH, `MCB_A_CYCH: rd_word = cyc_reg[63:32];
        `MCB_A_MRET, `MCB_A_RET:   rd_word = ret_reg[31:0];
        `MCB_A_MRETH, `MCB_A_RETH: rd_word = ret_reg[63:32];
        `MCB_A_TIME:    rd_word = machine_timer_unit[31:0];
        `MCB_A_TIMEH:   rd_word = machine_timer_unit[63:32];
        `MCB_A_MAKER:   rd_word = MAKER;
        `MCB_A_ARCH:    rd_word = ARCH;
        `MCB_A_IMPL:    rd_word = IMPL;
        `MCB_A_THREAD:  rd_word = THREAD;
        `MCB_A_CFGPTR:  rd_word = 32'h0;
        `MCB_A_XISA:    rd_word = XISA;
        default:        known = 1'b0;
      endcase
    end
  end

  // Top address bits 11:10 = 11 mark the read-only space; ISA and bad-value
  // registers sit elsewhere, so their writes are silently dropped.
  always_comb begin
    ill = !known;
    if (priv == MCB_PRIV_USER && csr_addr[9:8] == 2'b11) ill = 1'b1;
    if (csr_wr && (csr_addr[11:10] == 2'b11 || ro)) ill = 1'b1;
    if (priv == MCB_PRIV_USER) begin
      if (csr_addr == `MCB_A_CYC || csr_addr == `MCB_A_CYCH) ill |= !cnten_reg[0];
      if (csr_addr == `MCB_A_TIME || csr_addr == `MCB_A_TIMEH) ill |= !cnten_reg[1];
      if (csr_addr == `MCB_A_RET || csr_addr == `MCB_A_RETH) ill |= !cnten_reg[2];
    end
  end

  assign wr_ok = csr_req && csr_wr && !ill;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_reg   <= 1'b0;
      ill_reg   <= 1'b0;
      rdata_reg <= `MCB_RST_ZERO;
    end else begin
      ack_reg   <= csr_req;
      ill_reg   <= csr_req && ill;
      rdata_reg <= (csr_req && !ill) ? rd_word : 32'h0;
    end
  end

  // Trap entry outranks return, which outranks a software write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_blk_reg  <= 1'b0;
      prev_priv_reg <= MCB_PRIV_USER;
      prev_gie_reg  <= 1'b0;
      gie_reg       <= 1'b0;
    end else if (trap_entry) begin
      prev_gie_reg  <= gie_reg;
      gie_reg       <= 1'b0;
      prev_priv_reg <= priv;
    end else if (trap_return) begin
      gie_reg       <= prev_gie_reg;
      prev_gie_reg  <= 1'b1;
    end else if (hit(wr_ok, csr_addr, `MCB_A_STATUS)) begin
      wait_blk_reg  <= EXT_U && csr_wdata[`MCB_B_WFIBLK];
      prev_priv_reg <= (&csr_wdata[`MCB_B_PPRIV+1:`MCB_B_PPRIV] || !EXT_U) ? 2'b11 : 2'b00;
      prev_gie_reg  <= csr_wdata[`MCB_B_PGIE];
      gie_reg       <= csr_wdata[`MCB_B_GIE];
    end
  end

  // Fast pending bits: a new request wins over a clearing write of zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fast_pend_reg <= 16'h0;
    end else if (hit(wr_ok, csr_addr, `MCB_A_PEND)) begin
      fast_pend_reg <= (fast_pend_reg & csr_wdata[31:16]) | fast_irq_channel;
    end else begin
      fast_pend_reg <= fast_pend_reg | fast_irq_channel;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= gie_reg && !trap_entry && ((|(fast_en_reg & fast_pend_reg))
                 || (ext_en_reg && irq_ext) || (tim_en_reg && irq_timer));
    end
  end

  // Flags accumulate even in the cycle of a software write
  always_ff @(posedge clk) begin
    if (hit(wr_ok, csr_addr, `MCB_A_FPFLAG) || hit(wr_ok, csr_addr, `MCB_A_FPCTL)) begin
      fp_flags_reg <= csr_wdata[4:0] | fp_flags_set;
    end else begin
      fp_flags_reg <= fp_flags_reg | fp_flags_set;
    end
    if (hit(wr_ok, csr_addr, `MCB_A_FPRND)) fp_rnd_reg <= csr_wdata[2:0];
    else if (hit(wr_ok, csr_addr, `MCB_A_FPCTL)) fp_rnd_reg <= csr_wdata[7:5];
  end

  // Uninitialised storage: software sets these up after reset
  always_ff @(posedge clk) begin
    if (hit(wr_ok, csr_addr, `MCB_A_IEN)) begin
      fast_en_reg <= csr_wdata[31:`MCB_B_FAST];
      ext_en_reg  <= csr_wdata[`MCB_B_EXT];
      tim_en_reg  <= csr_wdata[`MCB_B_TIM];
    end
    if (hit(wr_ok, csr_addr, `MCB_A_TVEC)) tvec_reg <= csr_wdata[31:2];
    if (hit(wr_ok, csr_addr, `MCB_A_CNTEN)) cnten_reg <= csr_wdata[2:0];
    if (hit(wr_ok, csr_addr, `MCB_A_INHIBIT)) inhibit_reg <= csr_wdata & 32'hFFFF_FFFD;
    if (hit(wr_ok, csr_addr, `MCB_A_SCRATCH)) scratch_reg <= csr_wdata;
    if (trap_entry) begin
      epc_reg       <= trap_pc;
      cause_irq_reg <= trap_cause[31];
      cause_id_reg  <= trap_cause[4:0];
      tval_reg      <= trap_value;
    end else begin
      if (hit(wr_ok, csr_addr, `MCB_A_EPC)) epc_reg <= csr_wdata;
      if (hit(wr_ok, csr_addr, `MCB_A_CAUSE)) begin
        cause_irq_reg <= csr_wdata[31];
        cause_id_reg  <= csr_wdata[4:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (wr_ok && in_rng(csr_addr, `MCB_A_PCFG, 12'h4)) pcfg_reg[csr_addr[1:0]] <= csr_wdata;
    if (wr_ok && in_rng(csr_addr, `MCB_A_PADDR, 12'h10)) paddr_reg[csr_addr[3:0]] <= csr_wdata;
  end

  always_ff @(posedge clk) begin
    if (hit(wr_ok, csr_addr, `MCB_A_MCYC)) cyc_reg <= {cyc_reg[63:32], csr_wdata};
    else if (hit(wr_ok, csr_addr, `MCB_A_MCYCH)) cyc_reg <= {csr_wdata, cyc_reg[31:0]};
    else if (!inhibit_reg[0]) cyc_reg <= cyc_reg + 64'h1;
    if (hit(wr_ok, csr_addr, `MCB_A_MRET)) ret_reg <= {ret_reg[63:32], csr_wdata};
    else if (hit(wr_ok, csr_addr, `MCB_A_MRETH)) ret_reg <= {csr_wdata, ret_reg[31:0]};
    else if (!inhibit_reg[2] && retire) ret_reg <= ret_reg + 64'h1;
  end

  // Entries 0..2 of the counter arrays are never built
  for (genvar gi = 3; gi < 32; gi++) begin : g_hpm
    always_ff @(posedge clk) begin
      if (hit(wr_ok, csr_addr, `MCB_A_HPMEV + 12'(gi - 3))) hpm_ev_reg[gi] <= csr_wdata;
      if (hit(wr_ok, csr_addr, `MCB_A_HPMLO + 12'(gi - 3))) begin
        hpm_cnt_reg[gi] <= {hpm_cnt_reg[gi][63:32], csr_wdata};
      end else if (hit(wr_ok, csr_addr, `MCB_A_HPMHI + 12'(gi - 3))) begin
        hpm_cnt_reg[gi] <= {csr_wdata, hpm_cnt_reg[gi][31:0]};
      end else if (!inhibit_reg[gi] && |(hpm_ev_reg[gi] & perf_events)) begin
        hpm_cnt_reg[gi] <= hpm_cnt_reg[gi] + 64'h1;
      end
    end
  end

  assign csr_ack               = ack_reg;
  assign csr_illegal           = ill_reg;
  assign csr_rdata             = rdata_reg;
  assign irq_take              = irq_reg;
  assign fp_round_mode         = fp_rnd_reg;
  assign timeout_wait_disallow = wait_blk_reg;
  assign previous_privilege    = prev_priv_reg;
  assign trap_vector           = {tvec_reg, 2'b00};
  assign return_pc             = epc_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence trap_seq;
    trap_entry ##1 !gie_reg;
  endsequence

  trap_save_a: assert property (trap_entry |=> prev_gie_reg == $past(gie_reg) && !gie_reg)
    else $error("trap entry did not save and clear enable");
  trap_hold_a: assert property (trap_seq |-> !irq_reg)
    else $error("interrupt taken right after trap entry");
  ret_restore_a: assert property (trap_return && !trap_entry
      |=> gie_reg == $past(prev_gie_reg))
    else $error("return did not restore enable");
  isa_quiet_a: assert property (csr_req && csr_wr && csr_addr == `MCB_A_ISA
      && priv == MCB_PRIV_MACH |=> !csr_illegal)
    else $error("isa write flagged illegal");
  isa_const_a: assert property (csr_req && csr_addr == `MCB_A_ISA && priv == MCB_PRIV_MACH
      |=> csr_rdata[31:30] == 2'b01 && csr_rdata[23] && csr_rdata[8] == !EXT_E)
    else $error("isa constant bits wrong");
  fp_block_a: assert property (csr_req && !EXT_FP && csr_addr inside {[12'h001:12'h003]}
      |=> csr_illegal)
    else $error("float access allowed while disabled");
  user_mach_a: assert property (csr_req && priv == MCB_PRIV_USER && csr_addr[9:8] == 2'b11
      |=> csr_illegal && csr_rdata == 32'h0)
    else $error("user reached machine register");
  irq_gate_a: assert property (!gie_reg |=> !irq_take)
    else $error("interrupt taken with global enable off");
  status_mask_a: assert property (csr_req && csr_addr == `MCB_A_STATUS
      |=> (csr_rdata & ~`MCB_STATUS_MSK) == 32'h0)
    else $error("unimplemented status bits not zero");
  fp_view_a: assert property (csr_req && !csr_wr && csr_addr == `MCB_A_FPCTL && EXT_FP
      && priv == MCB_PRIV_MACH |=> csr_rdata[7:5] == $past(fp_rnd_reg))
    else $error("combined float view mismatch");
  tw_tied_a: assert property (!EXT_U |-> !timeout_wait_disallow)
    else $error("wait block set without user mode");

endmodule

// file: mcb_consts.svh
// Address map, field positions and reset values of the machine CSR bank.
// Assumes CSR addresses are the 12-bit numbers carried by the access port.
// Behaviour
// - With the float option off, any float CSR access is illegal.
// - Float flag register keeps five accrued exception flags in bits 4:0.
// - Dynamic rounding mode comes from rounding register bits 2:0.
// - Combined float register reads and writes the same flag and mode storage.
// - Environment config low/high read zero, read-only, exist only with user mode.
// - Status resets to zero; unimplemented status bits read zero, ignore writes.
// - Status bit 21 blocks user wait-for-interrupt; zero without user mode.
// - Status bits 12:11 keep previous privilege, 11 machine, 00 user.
// - Trap entry moves enable bit 3 into bit 7 and clears 3; return restores.
// - ISA register is read-only; writes ignored without an illegal flag.
// - ISA bits 31:30 always read 01 for 32-bit words.
// - ISA bit 23 always set for custom extensions.
// - ISA bits 20, 12, 2, 0 follow user, muldiv, compressed, atomic options.
// - ISA bit 4 shows embedded option; then bit 8 clear, else set.
// - Enable bits 31:16 gate sixteen fast interrupt channels, each writable.
// - Enable bit 11 gates external, bit 7 gates timer interrupt.
// - Interrupt taken only with its enable and the global enable both set.
// - Time words at 0xC01/0xC81 are read-only copies of the timer unit.
// - Writable cycle and retired counters, read-only user copies at 0xC0x and 0xC8x.
// - Protection config from 0x3A0, region addresses from 0x3B0, writable.
// - Event selectors 3..31 from 0x323, counters at 0xB03 and 0xB83.
// - Extended ISA register at 0xFC0 is read-only.
// - Writing read-only CSRs other than ISA and bad-value, or user access to machine CSRs, is illegal.
// - Unused bits read zero; unknown addresses raise illegal.
`ifndef MCB_CONSTS_SVH
`define MCB_CONSTS_SVH
`define MCB_A_FPFLAG   12'h001
`define MCB_A_FPRND    12'h002
`define MCB_A_FPCTL    12'h003
`define MCB_A_STATUS   12'h300
`define MCB_A_ISA      12'h301
`define MCB_A_IEN      12'h304
`define MCB_A_TVEC     12'h305
`define MCB_A_CNTEN    12'h306
`define MCB_A_ENVLO    12'h30A
`define MCB_A_MSTATH   12'h310
`define MCB_A_ENVHI    12'h31A
`define MCB_A_INHIBIT  12'h320
`define MCB_A_HPMEV    12'h323
`define MCB_A_SCRATCH  12'h340
`define MCB_A_EPC      12'h341
`define MCB_A_CAUSE    12'h342
`define MCB_A_TVAL     12'h343
`define MCB_A_PEND     12'h344
`define MCB_A_PCFG     12'h3A0
`define MCB_A_PADDR    12'h3B0
`define MCB_A_MCYC     12'hB00
`define MCB_A_MRET     12'hB02
`define MCB_A_HPMLO    12'hB03
`define MCB_A_MCYCH    12'hB80
`define MCB_A_MRETH    12'hB82
`define MCB_A_HPMHI    12'hB83
`define MCB_A_CYC      12'hC00
`define MCB_A_TIME     12'hC01
`define MCB_A_RET      12'hC02
`define MCB_A_CYCH     12'hC80
`define MCB_A_TIMEH    12'hC81
`define MCB_A_RETH     12'hC82
`define MCB_A_MAKER    12'hF11
`define MCB_A_ARCH     12'hF12
`define MCB_A_IMPL     12'hF13
`define MCB_A_THREAD   12'hF14
`define MCB_A_CFGPTR   12'hF15
`define MCB_A_XISA     12'hFC0
`define MCB_B_WFIBLK   21
`define MCB_B_PPRIV    11
`define MCB_B_PGIE     7
`define MCB_B_GIE      3
`define MCB_B_WLEN     30
`define MCB_B_X        23
`define MCB_B_U        20
`define MCB_B_M        12
`define MCB_B_I        8
`define MCB_B_E        4
`define MCB_B_C        2
`define MCB_B_A        0
`define MCB_B_EXT      11
`define MCB_B_TIM      7
`define MCB_B_FAST     16
`define MCB_WLEN_32    2'h1
`define MCB_RST_ZERO   32'h00000000
`define MCB_STATUS_MSK 32'h00201888
`endif

// file: mcb_pkg.sv
// Types shared by the machine CSR bank.
// Assumes the constants header is included by the users of this package.
package mcb_pkg;
  typedef enum logic [1:0] {
    MCB_PRIV_USER = 2'b00,
    MCB_PRIV_MACH = 2'b11
  } mcb_priv_e;
  typedef logic [31:0] mcb_word_t;
  typedef logic [11:0] mcb_addr_t;
endpackage

// file: mcb_csr_bank_tb.sv
// Self-checking bench for the machine CSR bank: CSR reads and writes, traps, interrupts.
// Assumes the default build options of the bank: user, muldiv, compressed and float on,
// plus a second build without user mode or float and with the embedded base.
`timescale 1ns/1ps
`include "mcb_consts.svh"
module mcb_csr_bank_tb;
  import mcb_pkg::*;
  logic        clk;
  logic        rst;
  logic        csr_req;
  logic        csr_wr;
  mcb_addr_t   csr_addr;
  mcb_word_t   csr_wdata;
  mcb_priv_e   priv;
  logic        csr_ack;
  logic        csr_illegal;
  mcb_word_t   csr_rdata;
  logic        trap_entry;
  logic        trap_return;
  mcb_word_t   trap_pc;
  mcb_word_t   trap_cause;
  mcb_word_t   trap_value;
  logic        irq_ext;
  logic        irq_timer;
  logic [15:0] fast_irq_channel;
  logic [4:0]  fp_flags_set;
  logic        retire;
  logic [31:0] perf_events;
  logic [63:0] machine_timer_unit;
  logic        irq_take;
  logic [2:0]  fp_round_mode;
  logic        timeout_wait_disallow;
  logic [1:0]  previous_privilege;
  mcb_word_t   trap_vector;
  mcb_word_t   return_pc;
  int          err_count;
  int          samples_checked;
  mcb_word_t   rd;
  logic        ill;
  logic        ill_min;
  mcb_word_t   rd_min;
  logic        min_ack;
  logic        min_ill;
  mcb_word_t   min_rdata;
  logic        min_wait_blk;
  mcb_csr_bank uut (
    .clk(clk), .rst(rst), .csr_req(csr_req), .csr_wr(csr_wr), .csr_addr(csr_addr),
    .csr_wdata(csr_wdata), .priv(priv), .csr_ack(csr_ack), .csr_illegal(csr_illegal),
    .csr_rdata(csr_rdata), .trap_entry(trap_entry), .trap_return(trap_return),
    .trap_pc(trap_pc), .trap_cause(trap_cause), .trap_value(trap_value),
    .irq_ext(irq_ext), .irq_timer(irq_timer), .fast_irq_channel(fast_irq_channel),
    .fp_flags_set(fp_flags_set), .retire(retire), .perf_events(perf_events),
    .machine_timer_unit(machine_timer_unit), .irq_take(irq_take),
    .fp_round_mode(fp_round_mode), .timeout_wait_disallow(timeout_wait_disallow),
    .previous_privilege(previous_privilege), .trap_vector(trap_vector),
    .return_pc(return_pc)
  );
  // Second build sees the same accesses; only its answers and wait block are watched
  mcb_csr_bank #(.EXT_U(1'b0), .EXT_E(1'b1), .EXT_FP(1'b0)) uut_min (
    .clk(clk), .rst(rst), .csr_req(csr_req), .csr_wr(csr_wr), .csr_addr(csr_addr),
    .csr_wdata(csr_wdata), .priv(priv), .csr_ack(min_ack), .csr_illegal(min_ill),
    .csr_rdata(min_rdata), .trap_entry(trap_entry), .trap_return(trap_return),
    .trap_pc(trap_pc), .trap_cause(trap_cause), .trap_value(trap_value),
    .irq_ext(irq_ext), .irq_timer(irq_timer), .fast_irq_channel(fast_irq_channel),
    .fp_flags_set(fp_flags_set), .retire(retire), .perf_events(perf_events),
    .machine_timer_unit(machine_timer_unit), .irq_take(),
    .fp_round_mode(), .timeout_wait_disallow(min_wait_blk),
    .previous_privilege(), .trap_vector(), .return_pc()
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input mcb_word_t seen, input mcb_word_t exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One access: request held for exactly one edge, answer taken one cycle later
  task automatic acc(input logic w, input mcb_addr_t a, input mcb_word_t d);
    csr_req = 1'b1;
    csr_wr = w;
    csr_addr = a;
    csr_wdata = d;
    @(posedge clk);
    #1;
    csr_req = 1'b0;
    csr_wr = 1'b0;
    chk({31'h0, csr_ack}, 32'h1);
    rd = csr_rdata;
    ill = csr_illegal;
    chk({31'h0, min_ack}, 32'h1);
    rd_min = min_rdata;
    ill_min = min_ill;
    @(posedge clk);
    #1;
  endtask
  task automatic rdchk(input mcb_addr_t a, input mcb_word_t exp);
    acc(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, ill}, 32'h0);
  endtask
  task automatic pulse_trap(input logic ret);
    trap_entry = ~ret;
    trap_return = ret;
    @(posedge clk);
    #1;
    trap_entry = 1'b0;
    trap_return = 1'b0;
    @(posedge clk);
    #1;
  endtask
  initial begin
    #200000;
    err_count++;
    end_of_test();
  end
  initial begin
    err_count = 0;
    samples_checked = 0;
    rst = 1'b1;
    csr_req = 1'b0;
    csr_wr = 1'b0;
    csr_addr = 12'h000;
    csr_wdata = 32'h0;
    priv = MCB_PRIV_MACH;
    trap_entry = 1'b0;
    trap_return = 1'b0;
    trap_pc = 32'h0000_1234;
    trap_cause = 32'h8000_000B;
    trap_value = 32'h0;
    irq_ext = 1'b0;
    irq_timer = 1'b0;
    fast_irq_channel = 16'h0000;
    fp_flags_set = 5'h00;
    retire = 1'b0;
    perf_events = 32'h0;
    machine_timer_unit = 64'h1234_5678_9ABC_DEF0;
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    rdchk(`MCB_A_STATUS, 32'h0000_0000);
    chk({30'h0, previous_privilege}, 32'h0);
    rdchk(`MCB_A_ISA, 32'h4090_1104);
    chk(rd_min, 32'h4080_1014);
    acc(1'b1, `MCB_A_ISA, 32'h0000_0000);
    chk({31'h0, ill}, 32'h0);
    rdchk(`MCB_A_ISA, 32'h4090_1104);
    rdchk(`MCB_A_ENVLO, 32'h0000_0000);
    chk({31'h0, ill_min}, 32'h1);
    rdchk(`MCB_A_ENVHI, 32'h0000_0000);
    acc(1'b1, `MCB_A_ENVLO, 32'hFFFF_FFFF);
    chk({31'h0, ill}, 32'h1);
    // Combined float view and its two halves share one store
    acc(1'b1, `MCB_A_FPCTL, 32'h0000_00E5);
    chk({31'h0, ill_min}, 32'h1);
    rdchk(`MCB_A_FPFLAG, 32'h0000_0005);
    rdchk(`MCB_A_FPRND, 32'h0000_0007);
    chk({29'h0, fp_round_mode}, 32'h7);
    acc(1'b1, `MCB_A_FPRND, 32'h0000_0002);
    acc(1'b1, `MCB_A_FPFLAG, 32'hFFFF_FFF3);
    rdchk(`MCB_A_FPCTL, 32'h0000_0053);
    // Status: only the implemented flags survive a write of all ones
    acc(1'b1, `MCB_A_STATUS, 32'hFFFF_FFFF);
    rdchk(`MCB_A_STATUS, 32'h0020_1888);
    chk(rd_min, 32'h0000_1888);
    chk({31'h0, min_wait_blk}, 32'h0);
    chk({31'h0, timeout_wait_disallow}, 32'h1);
    chk({30'h0, previous_privilege}, 32'h3);
    // Trap entry saves and clears the global enable, return restores it
    acc(1'b1, `MCB_A_STATUS, 32'h0000_1808);
    pulse_trap(1'b0);
    acc(1'b0, `MCB_A_STATUS, 32'h0);
    chk(rd & 32'h0000_0088, 32'h0000_0080);
    chk(return_pc, 32'h0000_1234);
    rdchk(`MCB_A_CAUSE, 32'h8000_000B);
    pulse_trap(1'b1);
    acc(1'b0, `MCB_A_STATUS, 32'h0);
    chk(rd & 32'h0000_0088, 32'h0000_0088);
    // External interrupt fires with its own and the global enable, stops when the global enable clears
    acc(1'b1, `MCB_A_IEN, 32'h0000_0800);
    rdchk(`MCB_A_IEN, 32'h0000_0800);
    irq_ext = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, irq_take}, 32'h1);
    acc(1'b1, `MCB_A_STATUS, 32'h0000_0000);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, irq_take}, 32'h0);
    irq_ext = 1'b0;
    // Timer enable with the global enable, with the timer line raised, also fires
    acc(1'b1, `MCB_A_IEN, 32'h0000_0080);
    acc(1'b1, `MCB_A_STATUS, 32'h0000_0008);
    irq_timer = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, irq_take}, 32'h1);
    irq_timer = 1'b0;
    // Fast channel 15: sticky pending, cleared by writing zero
    acc(1'b1, `MCB_A_IEN, 32'h8000_0000);
    rdchk(`MCB_A_IEN, 32'h8000_0000);
    fast_irq_channel = 16'h8000;
    @(posedge clk);
    #1;
    fast_irq_channel = 16'h0000;
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, irq_take}, 32'h1);
    acc(1'b0, `MCB_A_PEND, 32'h0);
    chk(rd & 32'hFFFF_0000, 32'h8000_0000);
    acc(1'b1, `MCB_A_PEND, 32'h0000_0000);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, irq_take}, 32'h0);
    rdchk(`MCB_A_TIME, 32'h9ABC_DEF0);
    rdchk(`MCB_A_TIMEH, 32'h1234_5678);
    acc(1'b1, `MCB_A_TIME, 32'h0);
    chk({31'h0, ill}, 32'h1);
    acc(1'b1, `MCB_A_MRET, 32'h0000_0100);
    acc(1'b1, `MCB_A_MRETH, 32'h0000_00A5);
    rdchk(`MCB_A_RET, 32'h0000_0100);
    rdchk(`MCB_A_RETH, 32'h0000_00A5);
    acc(1'b1, `MCB_A_RETH, 32'h0);
    chk({31'h0, ill}, 32'h1);
    acc(1'b1, 12'h3A3, 32'h0000_0F1F);
    rdchk(12'h3A3, 32'h0000_0F1F);
    acc(1'b1, `MCB_A_PADDR, 32'h1234_5678);
    rdchk(`MCB_A_PADDR, 32'h1234_5678);
    acc(1'b1, 12'h33F, 32'h0000_0003);
    rdchk(12'h33F, 32'h0000_0003);
    acc(1'b1, 12'hB9F, 32'h0000_0042);
    rdchk(12'hB9F, 32'h0000_0042);
    rdchk(`MCB_A_XISA, 32'h0000_0001);
    acc(1'b1, `MCB_A_XISA, 32'h0);
    chk({31'h0, ill}, 32'h1);
    acc(1'b0, 12'h7FF, 32'h0);
    chk({31'h0, ill}, 32'h1);
    chk(rd, 32'h0);
    acc(1'b1, `MCB_A_TVEC, 32'h0000_2003);
    rdchk(`MCB_A_TVEC, 32'h0000_2000);
    chk(trap_vector, 32'h0000_2000);
    // Cycle counter held by its inhibit bit so the written words read back
    acc(1'b1, `MCB_A_INHIBIT, 32'h0000_0001);
    acc(1'b1, `MCB_A_MCYC, 32'h0000_0055);
    acc(1'b1, `MCB_A_MCYCH, 32'h0000_0066);
    rdchk(`MCB_A_CYC, 32'h0000_0055);
    rdchk(`MCB_A_MCYCH, 32'h0000_0066);
    priv = MCB_PRIV_USER;
    acc(1'b0, `MCB_A_STATUS, 32'h0);
    chk({31'h0, ill}, 32'h1);
    priv = MCB_PRIV_MACH;
    end_of_test();
  end
endmodule
